// file: core/quad_dac_regs.svh
// Purpose: Constants for the two-wire port of the quad DAC.
// Assumes: Included by bare name; definitions only.
// Notes: Word bit positions count from the first bit shifted in (15).
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

// ****************************************************************
// Slave address
// ****************************************************************
`define ADDR_FIXED_HIGH 6'h06

// ****************************************************************
// Pointer byte fields
// ****************************************************************
`define PTR_SEL_MSB 3
`define PTR_SEL_LSB 0

// ****************************************************************
// Data word fields
// ****************************************************************
`define WORD_PM_HIGH 15
`define WORD_PM_LOW 14
`define WORD_CLEAR 13
`define WORD_LOAD 12
`define WORD_CODE_MSB 11
`define WORD_RESET_VALUE 16'h0000
`define WORD_DEFAULT_READ 16'h2000

// ****************************************************************
// Byte positions within a transfer
// ****************************************************************
`define BYTE_ADDRESS 3'h0
`define BYTE_POINTER 3'h1
`define BYTE_DATA_HIGH 3'h2
`define BYTE_DATA_LOW 3'h3
`define BYTE_EXTRA 3'h4
`define BIT_COUNT_BYTE 4'h8

`endif

// file: core/quad_dac_pkg.sv
// Purpose: Types shared by the quad DAC serial port.
// Assumes: Used by scoped name only, never imported.
// Notes: Constants live in quad_dac_regs.svh.
package quad_dac_pkg;

  // Link engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100
  } link_state_e;

  typedef logic [15:0] data_word_t;

endpackage

// file: core/sync_2ff.sv
// Purpose: Two flip-flop synchroniser for levels from another domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock.
  input wire logic rstN, // Active-low reset, already synchronised.
  input wire logic [WIDTH-1:0] asyncIn, // Level from outside the domain.
  output logic [WIDTH-1:0] syncOut // Level safe to use in clk domain.
);

  logic [WIDTH-1:0] stage1Reg;

  // Two stages give metastability time to settle before use.
  // Reset to the idle bus level so no false edge follows reset.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1Reg <= '1;
      syncOut <= '1;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end

endmodule

// file: core/quad_dac_serial_slave_port.sv
// Purpose: Two-wire slave port and command logic of a quad DAC.
// Assumes: clk far faster than SCL; SCL and SDA pass two flip-flops.
// Notes: SCL is only ever sampled; the port has no SCL driver at all.
`timescale 1ns/10ps
`include "quad_dac_regs.svh"

// Overview of operation
// - Power-up clears all input and DAC registers.
// - After reset: normal mode, all codes zero.
// - Slave only; SCL is never driven.
// - Address is 000110 plus address pin level.
// - Start condition begins address reception.
// - Matching address acknowledged; mismatch goes idle.
// - Nine clocks per byte, receiver acknowledges.
// - SDA changes only while SCL low.
// - Writes start with address and pointer byte.
// - Restart with read address returns channel data.
// - Pointer persists for address-only reads.
// - Pointer holds one select bit per channel.
// - Two data bytes form a 16-bit word.
// - Four control bits then left-justified code.
// - First two bits are power mode bits.
// - Bit 13 clear, bit 12 load, active low.
// - Code is straight binary, sets output.
// - Clear low zeroes all input and DAC registers.
// - Load low updates together only DAC registers whose input register was written since the last load.
// - Bits 15 and 14 select power mode.
// - Zero or multiple selects read default word.
module quad_dac_serial_slave_port #(
  parameter int RES = 12
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Asynchronous active-low reset.
  input wire logic scl, // Serial clock from the master.
  input wire logic sdaIn, // Level seen on the data line.
  input wire logic addressSelectPin, // Low address bit strap.
  output logic sdaOut, // Data line drive value, always low.
  output logic sdaOe, // High while this port pulls SDA low.
  output logic [4*RES-1:0] dacCodeFlat, // DAC register codes, A in low bits.
  output logic [7:0] powerModeFlat, // Power mode per channel, A in low bits.
  output logic [3:0] pointerSel // Stored channel selection, D..A.
);

  // ****************************************************************
  // Reset release and input synchronisation
  // ****************************************************************
  logic [1:0] rstPipeReg;
  logic rstN;
  logic sclS;
  logic sdaS;
  logic addrPinS;
  logic sclDReg;
  logic sdaDReg;

  // Reset asserts at once but releases only on a clock edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipeReg <= 2'h0;
    end else begin
      rstPipeReg <= {rstPipeReg[0], 1'b1};
    end
  end
  assign rstN = rstPipeReg[1];

  sync_2ff #(
    .WIDTH(3)
  ) inSync (
    .clk(clk),
    .rstN(rstN),
    .asyncIn({scl, sdaIn, addressSelectPin}),
    .syncOut({sclS, sdaS, addrPinS})
  );

  // Delayed copies of the clean levels give the edges.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclDReg <= 1'b1;
      sdaDReg <= 1'b1;
    end else begin
      sclDReg <= sclS;
      sdaDReg <= sdaS;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  // SCL is only sampled; this port has no SCL output.
  assign sclRise = sclS & ~sclDReg;
  assign sclFall = ~sclS & sclDReg;
  // SDA moving while SCL high marks start or stop.
  assign startDet = sclS & sclDReg & sdaDReg & ~sdaS;
  assign stopDet = sclS & sclDReg & ~sdaDReg & sdaS;

  // ****************************************************************
  // Link engine
  // ****************************************************************
  quad_dac_pkg::link_state_e stateReg;
  logic [3:0] bitCntReg;
  logic [2:0] byteIdxReg;
  logic [7:0] rxShiftReg;
  quad_dac_pkg::data_word_t txShiftReg;
  logic txLowReg;
  logic readModeReg;
  logic [6:0] myAddr;
  logic byteDone;
  quad_dac_pkg::data_word_t readWord;

  // Own address: fixed high bits, low bit from the strap.
  assign myAddr = {`ADDR_FIXED_HIGH, addrPinS};

  // A received byte is complete at the fall after its eighth bit.
  assign byteDone = (stateReg == quad_dac_pkg::ST_RX) && sclFall &&
                    (bitCntReg == `BIT_COUNT_BYTE);

  // The engine changes SDA only on SCL falls, so the line stays put
  // through every high phase.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stateReg <= quad_dac_pkg::ST_IDLE;
      bitCntReg <= 4'h0;
      byteIdxReg <= 3'h0;
      rxShiftReg <= 8'h00;
      txShiftReg <= `WORD_RESET_VALUE;
      txLowReg <= 1'b0;
      readModeReg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startDet) begin
      // Start or repeated start always restarts at an address.
      stateReg <= quad_dac_pkg::ST_RX;
      bitCntReg <= 4'h0;
      byteIdxReg <= `BYTE_ADDRESS;
      readModeReg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopDet) begin
      stateReg <= quad_dac_pkg::ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      unique case (stateReg)
        quad_dac_pkg::ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        quad_dac_pkg::ST_RX: begin
          if (sclRise) begin
            // Bits arrive first-to-last as MSB to LSB.
            rxShiftReg <= {rxShiftReg[6:0], sdaS};
            bitCntReg <= bitCntReg + 4'h1;
          end else if (byteDone) begin
            bitCntReg <= 4'h0;
            if (byteIdxReg == `BYTE_ADDRESS &&
                rxShiftReg[7:1] != myAddr) begin
              stateReg <= quad_dac_pkg::ST_IDLE;
            end else begin
              // Pull SDA low through the ninth clock.
              stateReg <= quad_dac_pkg::ST_RXACK;
              sdaOe <= 1'b1;
              if (byteIdxReg == `BYTE_ADDRESS) begin
                readModeReg <= rxShiftReg[0];
              end
            end
          end
        end
        quad_dac_pkg::ST_RXACK: begin
          if (sclFall) begin
            if (byteIdxReg != `BYTE_EXTRA) begin
              byteIdxReg <= byteIdxReg + 3'h1;
            end
            if (readModeReg) begin
              // Read address: send the selected word next.
              stateReg <= quad_dac_pkg::ST_TX;
              txShiftReg <= readWord;
              txLowReg <= 1'b0;
              sdaOe <= ~readWord[15];
            end else begin
              stateReg <= quad_dac_pkg::ST_RX;
              sdaOe <= 1'b0;
            end
          end
        end
        quad_dac_pkg::ST_TX: begin
          if (sclRise) begin
            bitCntReg <= bitCntReg + 4'h1;
          end else if (sclFall) begin
            if (bitCntReg == `BIT_COUNT_BYTE) begin
              // Release SDA so the master can answer.
              stateReg <= quad_dac_pkg::ST_TXACK;
              bitCntReg <= 4'h0;
              sdaOe <= 1'b0;
            end else begin
              txShiftReg <= {txShiftReg[14:0], 1'b0};
              sdaOe <= ~txShiftReg[14];
            end
          end
        end
        quad_dac_pkg::ST_TXACK: begin
          if (sclRise && sdaS) begin
            // Not-acknowledge: stay off the line until stop.
            stateReg <= quad_dac_pkg::ST_IDLE;
          end else if (sclFall) begin
            stateReg <= quad_dac_pkg::ST_TX;
            if (txLowReg) begin
              // Acknowledged after both bytes: repeat the same word.
              txShiftReg <= readWord;
              txLowReg <= 1'b0;
              sdaOe <= ~readWord[15];
            end else begin
              txShiftReg <= {txShiftReg[14:0], 1'b0};
              txLowReg <= 1'b1;
              sdaOe <= ~txShiftReg[14];
            end
          end
        end
        default: begin
          stateReg <= quad_dac_pkg::ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // The port only ever pulls the open-drain line low.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ****************************************************************
  // Pointer and write word capture
  // ****************************************************************
  quad_dac_pkg::data_word_t rxWordReg;
  logic wordReadyReg;
  logic commit;

  // Bytes after the address: pointer, then high and low data bytes.
  // Extra bytes are acknowledged but change nothing.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pointerSel <= 4'h0;
      rxWordReg <= `WORD_RESET_VALUE;
      wordReadyReg <= 1'b0;
    end else if (startDet || stopDet) begin
      wordReadyReg <= 1'b0;
    end else if (byteDone && !readModeReg) begin
      unique case (byteIdxReg)
        `BYTE_POINTER: begin
          // Only the select bits are kept.
          pointerSel <= rxShiftReg[`PTR_SEL_MSB:`PTR_SEL_LSB];
        end
        `BYTE_DATA_HIGH: begin
          rxWordReg[15:8] <= rxShiftReg;
        end
        `BYTE_DATA_LOW: begin
          rxWordReg[7:0] <= rxShiftReg;
          wordReadyReg <= 1'b1;
        end
        default: begin
          wordReadyReg <= wordReadyReg;
        end
      endcase
    end
  end

  // A write completes when stop or restart follows both data bytes.
  assign commit = wordReadyReg && (startDet || stopDet);

  // ****************************************************************
  // Input, DAC and power mode registers
  // ****************************************************************
  localparam logic [15:0] WORD_MASK = 16'(16'hFFFF << (12 - RES));

  quad_dac_pkg::data_word_t inWordReg [4];
  quad_dac_pkg::data_word_t inWordNext [4];
  logic [RES-1:0] dacReg [4];
  logic [RES-1:0] dacNext [4];
  logic [1:0] pmReg [4];
  logic [1:0] pmNext [4];
  logic [3:0] pendReg;
  logic [3:0] pendNext;
  quad_dac_pkg::data_word_t maskedWord;

  // Padding below the code is stored, and read back, as zero.
  assign maskedWord = rxWordReg & WORD_MASK;

  // Clear wins over load; load copies only changed input registers,
  // which avoids needless glitches on unchanged outputs.
  always_comb begin
    pendNext = pendReg;
    for (int c = 0; c < 4; c++) begin
      inWordNext[c] = inWordReg[c];
      dacNext[c] = dacReg[c];
      pmNext[c] = pmReg[c];
    end
    if (commit) begin
      if (!maskedWord[`WORD_CLEAR]) begin
        pendNext = 4'h0;
        for (int c = 0; c < 4; c++) begin
          inWordNext[c] = `WORD_RESET_VALUE;
          dacNext[c] = '0;
          pmNext[c] = 2'h0;
        end
      end else begin
        for (int c = 0; c < 4; c++) begin
          if (pointerSel[c]) begin
            inWordNext[c] = maskedWord;
            // Mode comes from the first two bits.
            pmNext[c] = {maskedWord[`WORD_PM_HIGH],
                         maskedWord[`WORD_PM_LOW]};
            pendNext[c] = 1'b1;
          end
        end
        if (!maskedWord[`WORD_LOAD]) begin
          for (int c = 0; c < 4; c++) begin
            if (pendNext[c]) begin
              // Left-justified straight binary code.
              dacNext[c] = inWordNext[c][`WORD_CODE_MSB -: RES];
            end
          end
          pendNext = 4'h0;
        end
      end
    end
  end

  // Power-up state: zero codes, normal mode.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pendReg <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        inWordReg[c] <= `WORD_RESET_VALUE;
        dacReg[c] <= '0;
        pmReg[c] <= 2'h0;
      end
    end else begin
      pendReg <= pendNext;
      for (int c = 0; c < 4; c++) begin
        inWordReg[c] <= inWordNext[c];
        dacReg[c] <= dacNext[c];
        pmReg[c] <= pmNext[c];
      end
    end
  end

  // Readback of exactly one selected channel; else default.
  always_comb begin
    unique case (pointerSel)
      4'h1: readWord = inWordReg[0];
      4'h2: readWord = inWordReg[1];
      4'h4: readWord = inWordReg[2];
      4'h8: readWord = inWordReg[3];
      default: readWord = `WORD_DEFAULT_READ;
    endcase
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dacCodeFlat <= '0;
      powerModeFlat <= 8'h00;
    end else begin
      for (int c = 0; c < 4; c++) begin
        dacCodeFlat[c*RES +: RES] <= dacReg[c];
        powerModeFlat[c*2 +: 2] <= pmReg[c];
      end
    end
  end

endmodule

// file: dv/quad_dac_serial_slave_port_props.sv
// Purpose: Port checks on the quad DAC two-wire slave.
// Assumes: Bound to the top module; sees only its ports.
// Notes: Windows allow for the two-flop input sync.
`timescale 1ns/10ps
module quad_dac_serial_slave_port_props #(
  parameter int RES = 12
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Async reset, active low.
  input wire logic scl, // Serial clock.
  input wire logic sdaIn, // Data line level.
  input wire logic addressSelectPin, // Address strap.
  input wire logic sdaOut, // Data drive value.
  input wire logic sdaOe, // Data pull-down enable.
  input wire logic [4*RES-1:0] dacCodeFlat, // DAC codes.
  input wire logic [7:0] powerModeFlat, // Power modes.
  input wire logic [3:0] pointerSel // Stored pointer.
);
  logic [5:0] hiCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A long SCL high span means the bus is idle, so the port must let go.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiCnt <= 6'h00;
    end else if (!scl) begin
      hiCnt <= 6'h00;
    end else if (hiCnt != 6'h3F) begin
      hiCnt <= hiCnt + 6'h01;
    end
  end
  // ************
  // Assertions
  // ************
  a_drive_only_low: assert property (
    sdaOe |-> !sdaOut) else $error("SDA driven high");
  a_oe_moves_low: assert property (
    $changed(sdaOe) |-> !scl && !$past(scl, 2))
    else $error("SDA moved while SCL high");
  a_code_at_end: assert property (
    $changed(dacCodeFlat) |-> scl && $past(scl, 4))
    else $error("DAC code moved mid transfer");
  a_mode_at_end: assert property (
    $changed(powerModeFlat) |-> scl && $past(scl, 4))
    else $error("Power mode moved mid transfer");
  a_pointer_low: assert property (
    $changed(pointerSel) |-> !scl) else $error("Pointer moved in SCL high");
  a_idle_released: assert property (
    hiCnt > 6'h14 |-> !sdaOe) else $error("SDA held on idle bus");
  a_start_quiet: assert property (
    scl && $fell(sdaIn) && !sdaOe |=> !sdaOe [*8])
    else $error("SDA driven at start");
  a_stop_quiet: assert property (
    scl && $rose(sdaIn) |=> !sdaOe [*8]) else $error("SDA driven at stop");
  // Main scenarios reached.
  c_commit: cover property ($changed(dacCodeFlat));
  c_drive: cover property ($rose(sdaOe));
  c_mode: cover property ($changed(powerModeFlat));
endmodule

bind quad_dac_serial_slave_port quad_dac_serial_slave_port_props #(
  .RES(RES)
) props_u (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
  .addressSelectPin(addressSelectPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .dacCodeFlat(dacCodeFlat), .powerModeFlat(powerModeFlat),
  .pointerSel(pointerSel)
);

// file: dv/i2c_master_model.sv
// Purpose: Two-wire bus master that drives the DAC port.
// Assumes: Paced by the bench clock; SDA has a pull-up.
// Notes: A bit slot is 25 clocks, 125 ns, plus the slow setting.
`timescale 1ns/10ps
module i2c_master_model (
  input wire logic clk, // Bench clock.
  input wire logic sdaWire, // Resolved data line.
  output logic scl, // Serial clock, stands high between frames.
  output logic sdaDrv // 0 pulls SDA low, 1 releases it.
);
  int slow;
  // Idle bus: both lines released.
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    slow = 0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // SDA moves mid-low so the slave never sees it change with SCL high.
  task automatic bit_slot(input logic v, output logic s);
    wait_clk(6 + slow);
    sdaDrv <= v;
    wait_clk(7);
    scl <= 1'b1;
    wait_clk(6);
    s = sdaWire;
    wait_clk(6);
    scl <= 1'b0;
  endtask
  task automatic start_cond();
    wait_clk(6);
    sdaDrv <= 1'b1;
    wait_clk(6);
    scl <= 1'b1;
    wait_clk(6);
    sdaDrv <= 1'b0;
    wait_clk(6);
    scl <= 1'b0;
  endtask
  task automatic stop_cond();
    wait_clk(6);
    sdaDrv <= 1'b0;
    wait_clk(7);
    scl <= 1'b1;
    wait_clk(6);
    sdaDrv <= 1'b1;
    wait_clk(20);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(nack, s);
  endtask
endmodule

// file: dv/quad_dac_serial_slave_port_bench.sv
// Purpose: Self-checking bench for the quad DAC two-wire port.
// Assumes: 12-bit variant; seeded random words and selections.
// Notes: Expected state is kept by model functions below.
`timescale 1ns/10ps
`include "quad_dac_regs.svh"
module quad_dac_serial_slave_port_bench;
  localparam int RES = 12;
  logic clk, rst_n, asp, sdaWire, sdaOut, sdaOe, scl, sdaDrv;
  logic [4*RES-1:0] dacCodeFlat;
  logic [7:0] powerModeFlat;
  logic [3:0] pointerSel, chg, ptr;
  logic [15:0] inReg [4];
  logic [RES-1:0] dacReg [4];
  logic [1:0] pmReg [4];
  int n_mismatch, checks;
  quad_dac_serial_slave_port #(.RES(RES)) dut_u (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire),
    .addressSelectPin(asp), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .dacCodeFlat(dacCodeFlat), .powerModeFlat(powerModeFlat),
    .pointerSel(pointerSel));
  i2c_master_model mst_u (
    .clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
  // Open-drain line: the pull-up wins unless someone pulls low.
  assign sdaWire = sdaDrv & ~sdaOe;
  // ************
  // Checking
  // ************
  task automatic chk_val(input string nm, input logic [47:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_ack(input string nm, input logic e, g);
    chk_val(nm, {47'h0, e}, {47'h0, g});
  endtask
  // Clear is applied last so that it wins over load.
  function automatic void model(input logic [3:0] sel, logic [15:0] w);
    ptr = sel;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        inReg[i] = w;
        pmReg[i] = w[`WORD_PM_HIGH:`WORD_PM_LOW];
        chg[i] = 1'b1;
      end
      if (!w[`WORD_LOAD] && chg[i]) begin
        dacReg[i] = inReg[i][`WORD_CODE_MSB -: RES];
        chg[i] = 1'b0;
      end
      if (!w[`WORD_CLEAR] || !rst_n) begin
        inReg[i] = 16'h0000;
        dacReg[i] = 12'h000;
        pmReg[i] = 2'h0;
        chg[i] = 1'b0;
      end
    end
  endfunction
  function automatic logic [15:0] exp_read();
    exp_read = `WORD_DEFAULT_READ;
    for (int i = 0; i < 4; i++) begin
      if (ptr[i] && $countones(ptr) == 1) begin
        exp_read = inReg[i];
      end
    end
  endfunction
  task automatic dac_write(input logic [3:0] sel, input logic [15:0] w);
    logic a0, a1, a2, a3;
    mst_u.start_cond();
    mst_u.send_byte({`ADDR_FIXED_HIGH, asp, 1'b0}, a0);
    mst_u.send_byte({4'h0, sel}, a1);
    mst_u.send_byte(w[15:8], a2);
    mst_u.send_byte(w[7:0], a3);
    mst_u.stop_cond();
    model(sel, w);
    chk_ack("write acks", 1'b1, a0 & a1 & a2 & a3);
    chk_val("dac codes", {dacReg[3], dacReg[2], dacReg[1], dacReg[0]},
      dacCodeFlat);
    chk_val("modes", {40'h0, pmReg[3], pmReg[2], pmReg[1], pmReg[0]},
      {40'h0, powerModeFlat});
  endtask
  task automatic dac_read(input logic usePtr, input logic [3:0] sel);
    logic a0, a1, a2;
    logic [7:0] hi, lo, hi2;
    a0 = 1'b1;
    a1 = 1'b1;
    mst_u.start_cond();
    if (usePtr) begin
      mst_u.send_byte({`ADDR_FIXED_HIGH, asp, 1'b0}, a0);
      mst_u.send_byte({4'h0, sel}, a1);
      mst_u.start_cond();
      ptr = sel;
    end
    mst_u.send_byte({`ADDR_FIXED_HIGH, asp, 1'b1}, a2);
    mst_u.recv_byte(1'b0, hi);
    mst_u.recv_byte(1'b0, lo);
    mst_u.recv_byte(1'b1, hi2);
    mst_u.stop_cond();
    chk_ack("read acks", 1'b1, a0 & a1 & a2);
    chk_val("read word", 48'(exp_read()), 48'({hi, lo}));
    chk_val("repeat byte", 48'(hi), 48'(hi2));
    chk_val("pointer", 48'(ptr), 48'(pointerSel));
  endtask
  task automatic bad_addr(input logic [7:0] b);
    logic a;
    mst_u.start_cond();
    mst_u.send_byte(b, a);
    mst_u.stop_cond();
    chk_ack("foreign ack", 1'b0, a);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ************
  // Stimulus
  // ************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs about 34k clocks; this cuts a hang short.
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_n = 1'b0;
    asp = 1'b0;
    model(4'h0, 16'h0000);
    void'($urandom(60482));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    asp <= 1'($urandom);
    repeat (10) @(posedge clk);
    chk_val("reset codes", 48'h0, dacCodeFlat);
    chk_val("reset modes", 48'h0, 48'(powerModeFlat));
    dac_read(1'b0, 4'h0);
    bad_addr({`ADDR_FIXED_HIGH, ~asp, 1'b0});
    bad_addr({6'h07, asp, 1'b0});
    dac_write(4'h1, 16'h3FFF);
    dac_write(4'h2, 16'h6ABC);
    dac_read(1'b1, 4'h1);
    dac_write(4'hF, 16'hF123);
    dac_read(1'b1, 4'h3);
    dac_write(4'h4, 16'h1000);
    @(posedge clk);
    asp <= ~asp;
    repeat (5) @(posedge clk);
    for (int n = 0; n < 10; n++) begin
      mst_u.slow = $urandom_range(0, 9);
      dac_write(4'($urandom), {14'($urandom), 2'($urandom)} | 16'h2000);
      dac_read(1'($urandom), 4'($urandom));
    end
    end_sim();
  end
endmodule
